// >>> core/har_defines.svh
// Constants for the health attribute record builder
`ifndef HAR_DEFINES_SVH
`define HAR_DEFINES_SVH

// Record placement inside the 512-byte data sector
`define HAR_REC_BASE    9'h002
`define HAR_REC_LEN     9'h00c
`define HAR_REC_COUNT   6

// Byte offsets inside one record
`define HAR_OFF_ID      4'h0
`define HAR_OFF_FLAGLO  4'h1
`define HAR_OFF_FLAGHI  4'h2
`define HAR_OFF_CUR     4'h3
`define HAR_OFF_WORST   4'h4
`define HAR_OFF_RAW     4'h5
`define HAR_OFF_RSVD    4'hb

// Attribute identifiers
`define HAR_ID_SPARE    8'hc4
`define HAR_ID_WCHIP    8'hd5
`define HAR_ID_ERASE    8'he5
`define HAR_ID_ECCTOT   8'hcb
`define HAR_ID_ECCCOR   8'hcc
`define HAR_ID_CRC      8'hc7

// Flag words and fixed values
`define HAR_FLAG_PREF   16'h0003
`define HAR_FLAG_ADV    16'h0002
`define HAR_PCT_FULL    8'h64
`define HAR_RSVD_BYTE   8'h00

`endif

// >>> core/har_pkg.sv
// Types shared by the health attribute record builder
package har_pkg;

    // Scan sequencer states, one-hot
    typedef enum logic [3:0] {
        HAR_ST_CHIP_GO    = 4'b0001,
        HAR_ST_CHIP_WAIT  = 4'b0010,
        HAR_ST_ERASE_GO   = 4'b0100,
        HAR_ST_ERASE_WAIT = 4'b1000
    } har_state_t;

endpackage

// >>> core/har_divider.sv
// Sequential restoring divider used for the percentage figures
`timescale 1ns/1ps
`default_nettype none

module har_divider #(
    parameter int W = 56
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // Request
    input  wire logic         start,
    input  wire logic [W-1:0] dividend,
    input  wire logic [W-1:0] divisor,
    // Result
    output logic [W-1:0]      quotient,
    output logic              done
);

    localparam int CNTW = $clog2(W + 1);

    typedef struct packed {
        logic            busy;
        logic [CNTW-1:0] cnt;
        logic [W-1:0]    quo;
        logic [W-1:0]    rem;
        logic            done;
    } har_div_state_t;

    har_div_state_t s;
    har_div_state_t next_s;

    // One quotient bit per cycle; W+1 cycles from start to done
    always_comb begin
        logic [W:0] shifted;
        logic [W:0] diff;
        shifted = {s.rem, s.quo[W-1]};
        diff    = shifted - {1'b0, divisor};
        next_s      = s;
        next_s.done = 1'b0;
        if (s.busy) begin
            next_s.quo = {s.quo[W-2:0], ~diff[W]};
            next_s.rem = diff[W] ? shifted[W-1:0] : diff[W-1:0];
            next_s.cnt = s.cnt - CNTW'(1);
            if (s.cnt == CNTW'(1)) begin
                next_s.busy = 1'b0;
                next_s.done = 1'b1;
            end
        end else if (start) begin
            next_s.busy = 1'b1;
            next_s.cnt  = CNTW'(W);
            next_s.quo  = dividend;
            next_s.rem  = '0;
        end
        if (!rst_b) begin
            next_s = '0;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        s <= next_s;
    end

    assign quotient = s.quo;
    assign done     = s.done;

endmodule

`default_nettype wire

// >>> core/har_records.sv
// Health attribute record builder: six 12-byte records and verdict
// Notes on behaviour
// - Spare record: id c4h, flags 0003h, pre-fail and refreshed live.
// - Spare value is the minimum over chips of 100*current/initial.
// - Spare bytes 5-7 hold summed initial, 8-10 summed current counts.
// - Spare value below its threshold raises threshold-exceeded.
// - Worst-chip record: id D5h, flags 0003h, value and worst fixed 64h.
// - Worst-chip bytes 5-7 initial, 8-10 current of the fewest-spare chip.
// - Erase record: id E5h, flags 0003h, pre-fail and refreshed live.
// - Erase value estimates remaining life percent from erases per target.
// - Erase bytes 5-10 hold the estimated total block erases.
// - Erase value below its threshold raises threshold-exceeded.
// - Total ECC record: id CBh, flags 0002h, bytes 5-8 all ECC errors.
// - Correctable record: id CCh, bytes 5-8 count correctable errors only.
// - Bus CRC record: id C7h, bytes 5-8 count bus CRC errors.
// - The three error counters never affect the threshold verdict.
// - Byte 4 holds the worst value; byte 11 reads as zero.
// - Advisory counter records read 64h as value and worst value.
// - Records are consecutive 12-byte entries starting at sector byte 2.
// - Multi-byte fields are stored least significant byte first.
`timescale 1ns/1ps
`default_nettype none
`include "har_defines.svh"

module har_records #(
    parameter int NCHIPS = 4,
    parameter int CW     = 16
) (
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         rst_b,
    // Per-chip spare block counts from firmware
    input  wire logic [NCHIPS-1:0][CW-1:0]    chipInitSpare,
    input  wire logic [NCHIPS-1:0][CW-1:0]    chipCurSpare,
    // Wear figures from firmware
    input  wire logic [47:0]                  eraseTotal,
    input  wire logic [47:0]                  eraseBudget,
    // Error events, one-cycle pulses
    input  wire logic                         eccErrEvt,
    input  wire logic                         eccErrCorrectable,
    input  wire logic                         crcErrEvt,
    // Thresholds from the threshold sector
    input  wire logic [7:0]                   spareThreshold,
    input  wire logic [7:0]                   eraseThreshold,
    // Sector byte read port
    input  wire logic                         rdReq,
    input  wire logic [8:0]                   rdAddr,
    output logic                              rdValid,
    output logic [7:0]                        rdData,
    // Return-status verdict
    output logic                              thresholdExceeded
);

    localparam int DW   = 56;
    // Index width; a single chip still needs one bit
    localparam int IDXW = (NCHIPS > 1) ? $clog2(NCHIPS) : 1;

    typedef struct packed {
        har_pkg::har_state_t st;
        logic [IDXW-1:0]     chip;
        // Running scan values
        logic [7:0]          tmpMin;
        logic [23:0]         tmpSumInit;
        logic [23:0]         tmpSumCur;
        logic [CW-1:0]       tmpWInit;
        logic [CW-1:0]       tmpWCur;
        // Published attribute values
        logic [7:0]          spareVal;
        logic [7:0]          spareWorst;
        logic [23:0]         sumInit;
        logic [23:0]         sumCur;
        logic [23:0]         wInit;
        logic [23:0]         wCur;
        logic [7:0]          lifeVal;
        logic [7:0]          lifeWorst;
        logic [47:0]         eraseRaw;
        // Error counters
        logic [31:0]         eccTotal;
        logic [31:0]         eccCorr;
        logic [31:0]         crcCnt;
        // Outputs
        logic                divStart;
        logic                rdValid;
        logic [7:0]          rdData;
        logic                verdict;
    } har_state_rec_t;

    har_state_rec_t s;
    har_state_rec_t next_s;

    logic [DW-1:0] divDividend;
    logic [DW-1:0] divDivisor;
    logic [DW-1:0] divQuotient;
    logic          divDone;

    // Saturating increment shared by all error counters
    function automatic logic [31:0] satInc(input logic [31:0] v,
                                           input logic        evt);
        satInc = v;
        if (evt && (v != 32'hffff_ffff)) begin
            satInc = v + 32'h0000_0001;
        end
    endfunction

    // Saturating 24-bit accumulate for the spare sums
    function automatic logic [23:0] satAdd(input logic [23:0] a,
                                           input logic [CW-1:0] b);
        logic [24:0] sum;
        sum = {1'b0, a} + 25'(b);
        satAdd = sum[24] ? 24'hff_ffff : sum[23:0];
    endfunction

    // Percentage clamp: a quotient above 100 reads as 100
    function automatic logic [7:0] clampPct(input logic [DW-1:0] q);
        clampPct = (q > DW'(`HAR_PCT_FULL)) ? `HAR_PCT_FULL : q[7:0];
    endfunction

    // One byte of a generic record, fields low byte first
    function automatic logic [7:0] recByte(input logic [3:0]  off,
                                           input logic [7:0]  id,
                                           input logic [15:0] flags,
                                           input logic [7:0]  cur,
                                           input logic [7:0]  worst,
                                           input logic [47:0] raw);
        logic [47:0] shifted;
        // Low offsets never use the shifted value
        shifted = raw >> (6'(off - `HAR_OFF_RAW) * 6'h08);
        recByte = `HAR_RSVD_BYTE;
        if (off == `HAR_OFF_ID) begin
            recByte = id;
        end else if (off == `HAR_OFF_FLAGLO) begin
            recByte = flags[7:0];
        end else if (off == `HAR_OFF_FLAGHI) begin
            recByte = flags[15:8];
        end else if (off == `HAR_OFF_CUR) begin
            recByte = cur;
        end else if (off == `HAR_OFF_WORST) begin
            recByte = worst;
        end else if (off >= `HAR_OFF_RAW && off < `HAR_OFF_RSVD) begin
            recByte = shifted[7:0];
        end
    endfunction

    // Divider operands follow the scan state
    always_comb begin
        if (s.st == har_pkg::HAR_ST_ERASE_GO ||
            s.st == har_pkg::HAR_ST_ERASE_WAIT) begin
            // Erase count times 100 still fits in DW
            divDividend = DW'(eraseTotal) * DW'(`HAR_PCT_FULL);
            divDivisor  = DW'(eraseBudget);
        end else begin
            divDividend = DW'(chipCurSpare[s.chip]) * DW'(`HAR_PCT_FULL);
            divDivisor  = DW'(chipInitSpare[s.chip]);
        end
    end

    har_divider #(
        .W        (DW)
    ) u_div (
        .clk      (clk),
        .rst_b    (rst_b),
        .start    (s.divStart),
        .dividend (divDividend),
        .divisor  (divDivisor),
        .quotient (divQuotient),
        .done     (divDone)
    );

    // Next state: scan sequencer, counters and read port
    always_comb begin
        logic [7:0]  pct;
        logic [7:0]  life;
        logic [8:0]  base;
        logic [3:0]  off;
        logic [2:0]  sel;
        logic        hit;
        logic [7:0]  rb;
        pct  = `HAR_PCT_FULL;
        life = `HAR_PCT_FULL;
        base = `HAR_REC_BASE;
        off  = 4'h0;
        sel  = 3'h0;
        hit  = 1'b0;
        rb   = `HAR_RSVD_BYTE;
        next_s          = s;
        next_s.divStart = 1'b0;

        // Error counters run every cycle, independent of the scan
        // A full counter stays full
        next_s.eccTotal = satInc(s.eccTotal, eccErrEvt);
        next_s.eccCorr  = satInc(s.eccCorr,
                                 eccErrEvt && eccErrCorrectable);
        next_s.crcCnt   = satInc(s.crcCnt, crcErrEvt);

        // Endless scan: every chip, then the wear estimate
        case (s.st)
            har_pkg::HAR_ST_CHIP_GO: begin
                next_s.divStart = 1'b1;
                next_s.st       = har_pkg::HAR_ST_CHIP_WAIT;
            end
            har_pkg::HAR_ST_CHIP_WAIT: begin
                if (divDone) begin
                    // A chip with no spares at all counts as full
                    if (chipInitSpare[s.chip] != '0) begin
                        pct = clampPct(divQuotient);
                    end
                    if (pct < s.tmpMin) begin
                        next_s.tmpMin = pct;
                    end
                    next_s.tmpSumInit = satAdd(s.tmpSumInit,
                                               chipInitSpare[s.chip]);
                    next_s.tmpSumCur  = satAdd(s.tmpSumCur,
                                               chipCurSpare[s.chip]);
                    // Ties keep the lower chip so the choice is stable
                    if (s.chip == '0 ||
                        chipCurSpare[s.chip] < s.tmpWCur) begin
                        next_s.tmpWInit = chipInitSpare[s.chip];
                        next_s.tmpWCur  = chipCurSpare[s.chip];
                    end
                    if (s.chip == IDXW'(NCHIPS - 1)) begin
                        next_s.st   = har_pkg::HAR_ST_ERASE_GO;
                        next_s.chip = '0;
                    end else begin
                        next_s.st   = har_pkg::HAR_ST_CHIP_GO;
                        next_s.chip = s.chip + IDXW'(1);
                    end
                end
            end
            har_pkg::HAR_ST_ERASE_GO: begin
                // Publish the finished spare scan as one consistent set
                next_s.spareVal = s.tmpMin;
                if (s.tmpMin < s.spareWorst) begin
                    next_s.spareWorst = s.tmpMin;
                end
                next_s.sumInit    = s.tmpSumInit;
                next_s.sumCur     = s.tmpSumCur;
                next_s.wInit      = 24'(s.tmpWInit);
                next_s.wCur       = 24'(s.tmpWCur);
                // Next sweep starts from full health
                next_s.tmpMin     = `HAR_PCT_FULL;
                next_s.tmpSumInit = '0;
                next_s.tmpSumCur  = '0;
                next_s.divStart   = 1'b1;
                next_s.st         = har_pkg::HAR_ST_ERASE_WAIT;
            end
            har_pkg::HAR_ST_ERASE_WAIT: begin
                if (divDone) begin
                    // Used life is clamped, so remaining never goes negative
                    if (eraseBudget != '0) begin
                        life = `HAR_PCT_FULL - clampPct(divQuotient);
                    end
                    next_s.lifeVal  = life;
                    if (life < s.lifeWorst) begin
                        next_s.lifeWorst = life;
                    end
                    next_s.eraseRaw = eraseTotal;
                    next_s.st       = har_pkg::HAR_ST_CHIP_GO;
                end
            end
            default: begin
                next_s.st = har_pkg::HAR_ST_CHIP_GO;
            end
        endcase

        // Verdict uses only the two pre-fail values, not the counters
        next_s.verdict = (s.spareVal < spareThreshold) ||
                         (s.lifeVal < eraseThreshold);

        // Locate the record and the offset within it
        // Records never overlap, so one hit at most
        for (int k = 0; k < `HAR_REC_COUNT; k++) begin
            if (rdAddr >= base &&
                rdAddr < base + `HAR_REC_LEN) begin
                hit = 1'b1;
                sel = 3'(k);
                off = 4'(rdAddr - base);
            end
            base = base + `HAR_REC_LEN;
        end

        // Byte lookup; bytes outside the records read zero here
        if (hit) begin
            case (sel)
                3'h0: rb = recByte(off, `HAR_ID_SPARE,
                                   `HAR_FLAG_PREF, s.spareVal,
                                   s.spareWorst,
                                   {s.sumCur, s.sumInit});
                3'h1: rb = recByte(off, `HAR_ID_WCHIP,
                                   `HAR_FLAG_PREF, `HAR_PCT_FULL,
                                   `HAR_PCT_FULL,
                                   {s.wCur, s.wInit});
                3'h2: rb = recByte(off, `HAR_ID_ERASE,
                                   `HAR_FLAG_PREF, s.lifeVal,
                                   s.lifeWorst, s.eraseRaw);
                3'h3: rb = recByte(off, `HAR_ID_ECCTOT,
                                   `HAR_FLAG_ADV, `HAR_PCT_FULL,
                                   `HAR_PCT_FULL,
                                   {16'h0000, s.eccTotal});
                3'h4: rb = recByte(off, `HAR_ID_ECCCOR,
                                   `HAR_FLAG_ADV, `HAR_PCT_FULL,
                                   `HAR_PCT_FULL,
                                   {16'h0000, s.eccCorr});
                3'h5: rb = recByte(off, `HAR_ID_CRC,
                                   `HAR_FLAG_ADV, `HAR_PCT_FULL,
                                   `HAR_PCT_FULL,
                                   {16'h0000, s.crcCnt});
                default: rb = `HAR_RSVD_BYTE;
            endcase
        end
        // Data is held until the next request
        next_s.rdValid = rdReq;
        if (rdReq) begin
            next_s.rdData = rb;
        end

        // Synchronous reset: values read full health until first scan
        if (!rst_b) begin
            next_s            = '0;
            next_s.st         = har_pkg::HAR_ST_CHIP_GO;
            next_s.tmpMin     = `HAR_PCT_FULL;
            next_s.spareVal   = `HAR_PCT_FULL;
            next_s.spareWorst = `HAR_PCT_FULL;
            next_s.lifeVal    = `HAR_PCT_FULL;
            next_s.lifeWorst  = `HAR_PCT_FULL;
        end
    end

    // All state held in one register
    always_ff @(posedge clk) begin
        s <= next_s;
    end

    // Outputs straight from flip-flops
    assign rdValid           = s.rdValid;
    assign rdData            = s.rdData;
    assign thresholdExceeded = s.verdict;

endmodule

`default_nettype wire

// >>> dv/har_host_model.sv
// Host-side reader model that fetches data sector bytes
`timescale 1ns/1ps
`default_nettype none

module har_host_model (
    // Clock
    input  wire logic       clk,
    // Answer from the record builder
    input  wire logic       rdValid,
    input  wire logic [7:0] rdData,
    // Request to the record builder
    output logic            rdReq,
    output logic [8:0]      rdAddr
);
    // Idle with no request and a meaningless address
    initial begin
        rdReq  = 1'b0;
        rdAddr = 9'h1ff;
    end

    // One byte: request stands for one edge, answer taken one edge later
    task automatic read_byte(input logic [8:0] a, output logic [7:0] d,
                             output bit ok);
        @(negedge clk);
        rdReq  = 1'b1;
        rdAddr = a;
        @(negedge clk);
        rdReq  = 1'b0;
        rdAddr = ~a;    // No longer qualified, so show something else
        ok     = (rdValid === 1'b1);
        d      = rdData;
    endtask
endmodule

`default_nettype wire

// >>> dv/har_records_props.sv
// Port checker for the health attribute record builder
`timescale 1ns/1ps
`default_nettype none

module har_records_props #(
    parameter int NCHIPS = 4,
    parameter int CW     = 16
) (
    // Clock and reset
    input wire logic                      clk,
    input wire logic                      rst_b,
    // Firmware figures
    input wire logic [NCHIPS-1:0][CW-1:0] chipInitSpare,
    input wire logic [NCHIPS-1:0][CW-1:0] chipCurSpare,
    input wire logic [47:0]               eraseTotal,
    input wire logic [47:0]               eraseBudget,
    // Error events
    input wire logic                      eccErrEvt,
    input wire logic                      eccErrCorrectable,
    input wire logic                      crcErrEvt,
    // Thresholds
    input wire logic [7:0]                spareThreshold,
    input wire logic [7:0]                eraseThreshold,
    // Read port and verdict
    input wire logic                      rdReq,
    input wire logic [8:0]                rdAddr,
    input wire logic                      rdValid,
    input wire logic [7:0]                rdData,
    input wire logic                      thresholdExceeded
);
    logic [7:0] idExp;

    // Identifier expected at each record's first byte, zero elsewhere
    always_comb begin
        case (rdAddr)
            9'h002:  idExp = 8'hc4;
            9'h00e:  idExp = 8'hd5;
            9'h01a:  idExp = 8'he5;
            9'h026:  idExp = 8'hcb;
            9'h032:  idExp = 8'hcc;
            9'h03e:  idExp = 8'hc7;
            default: idExp = 8'h00;
        endcase
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    AST_ANSWER_NEXT: assert property (rdReq |=> rdValid)
        else $error("read not answered next cycle");
    AST_NO_EXTRA: assert property (!rdReq |=> !rdValid)
        else $error("answer without request");
    AST_HOLD_DATA: assert property (!rdReq |=> $stable(rdData))
        else $error("read data moved without request");
    AST_IDS: assert property (rdReq && idExp != 8'h00
        |=> rdData == $past(idExp)) else $error("wrong identifier");
    AST_PREF_FLAGS: assert property (rdReq && rdAddr inside
        {9'h003, 9'h00f, 9'h01b} |=> rdData == 8'h03)
        else $error("wrong pre-fail flags");
    AST_RSVD: assert property (rdReq && rdAddr inside
        {9'h00d, 9'h019, 9'h025, 9'h031, 9'h03d, 9'h049}
        |=> rdData == 8'h00) else $error("reserved byte not zero");
    AST_FIXED_100: assert property (rdReq && rdAddr inside
        {9'h011, 9'h012, 9'h029, 9'h02a, 9'h035, 9'h036, 9'h041, 9'h042}
        |=> rdData == 8'h64) else $error("fixed value not 64h");
    AST_OUTSIDE: assert property (rdReq && (rdAddr < 9'h002
        || rdAddr > 9'h049) |=> rdData == 8'h00)
        else $error("byte outside records not zero");
    AST_NO_THRESHOLD: assert property (((spareThreshold == 8'h00)
        && (eraseThreshold == 8'h00)) [*2] |=> !thresholdExceeded)
        else $error("verdict raised with zero thresholds");

    // Main scenarios reached
    CV_BACK_READ: cover property (rdReq ##1 rdValid);
    CV_VERDICT: cover property ($rose(thresholdExceeded));
    CV_BOTH_ERR: cover property (eccErrEvt && crcErrEvt);
endmodule

bind har_records har_records_props #(.NCHIPS(NCHIPS), .CW(CW))
    har_records_props_i (.clk(clk), .rst_b(rst_b),
    .chipInitSpare(chipInitSpare), .chipCurSpare(chipCurSpare),
    .eraseTotal(eraseTotal), .eraseBudget(eraseBudget),
    .eccErrEvt(eccErrEvt), .eccErrCorrectable(eccErrCorrectable),
    .crcErrEvt(crcErrEvt), .spareThreshold(spareThreshold),
    .eraseThreshold(eraseThreshold), .rdReq(rdReq), .rdAddr(rdAddr),
    .rdValid(rdValid), .rdData(rdData),
    .thresholdExceeded(thresholdExceeded));

`default_nettype wire

// >>> dv/tb.sv
// Testbench for the health attribute record builder
`timescale 1ns/1ps
`default_nettype none

module tb;
    localparam int NCHIPS = 4;
    localparam int CW     = 16;
    logic                      clk;
    logic                      rst_b;
    logic [NCHIPS-1:0][CW-1:0] chipInitSpare;
    logic [NCHIPS-1:0][CW-1:0] chipCurSpare;
    logic [47:0]               eraseTotal;
    logic [47:0]               eraseBudget;
    logic                      eccErrEvt;
    logic                      eccErrCorrectable;
    logic                      crcErrEvt;
    logic [7:0]                spareThreshold;
    logic [7:0]                eraseThreshold;
    wire logic                 rdReq;
    wire logic [8:0]           rdAddr;
    wire logic                 rdValid;
    wire logic [7:0]           rdData;
    wire logic                 thresholdExceeded;
    int                        num_errors;
    int                        checks;
    logic [7:0]                expByte [0:73];

    har_records #(.NCHIPS(NCHIPS), .CW(CW)) har_records_i (.clk(clk),
        .rst_b(rst_b), .chipInitSpare(chipInitSpare),
        .chipCurSpare(chipCurSpare), .eraseTotal(eraseTotal),
        .eraseBudget(eraseBudget), .eccErrEvt(eccErrEvt),
        .eccErrCorrectable(eccErrCorrectable), .crcErrEvt(crcErrEvt),
        .spareThreshold(spareThreshold), .eraseThreshold(eraseThreshold),
        .rdReq(rdReq), .rdAddr(rdAddr), .rdValid(rdValid),
        .rdData(rdData), .thresholdExceeded(thresholdExceeded));

    har_host_model har_host_model_i (.clk(clk), .rdValid(rdValid),
        .rdData(rdData), .rdReq(rdReq), .rdAddr(rdAddr));

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic check_val(input logic [47:0] seen, input logic [47:0] exp,
                             input string msg);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Expected image of one record; worst equals value after a single drop
    task automatic put_rec(input int k, input logic [7:0] id,
                           input logic [15:0] fl, input logic [7:0] v,
                           input logic [47:0] raw);
        int b;
        b = 2 + 12 * k;
        expByte[b]     = id;
        expByte[b + 1] = fl[7:0];
        expByte[b + 2] = fl[15:8];
        expByte[b + 3] = v;
        expByte[b + 4] = v;
        for (int i = 0; i < 6; i++)
            expByte[b + 5 + i] = raw[8 * i +: 8];
        expByte[b + 11] = 8'h00;
    endtask

    // Whole record area plus neighbours, compared byte by byte
    task automatic s_sector(input logic [31:0] nTot, input logic [31:0] nCor,
                            input logic [31:0] nCrc);
        logic [7:0] d;
        bit         ok;
        for (int a = 0; a < 74; a++)
            expByte[a] = 8'h00;
        put_rec(0, 8'hc4, 16'h0003, 8'h19, {24'd95, 24'd120});
        put_rec(1, 8'hd5, 16'h0003, 8'h64, {24'd5, 24'd20});
        put_rec(2, 8'he5, 16'h0003, 8'h46, 48'd300);
        put_rec(3, 8'hcb, 16'h0002, 8'h64, {16'h0000, nTot});
        put_rec(4, 8'hcc, 16'h0002, 8'h64, {16'h0000, nCor});
        put_rec(5, 8'hc7, 16'h0002, 8'h64, {16'h0000, nCrc});
        for (int a = 0; a < 80; a++) begin
            har_host_model_i.read_byte(9'(a), d, ok);
            check_val({47'h0, ok}, 48'h1, "read unanswered");
            check_val({40'h0, d}, (a < 74) ? {40'h0, expByte[a]} : 48'h0,
                      "sector byte");
        end
    endtask

    // Verdict follows each threshold across its strict boundary
    task automatic s_verdict();
        logic [7:0] spT [4]  = '{8'h1a, 8'h19, 8'h00, 8'h00};
        logic [7:0] erT [4]  = '{8'h00, 8'h00, 8'h47, 8'h46};
        logic       want [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            spareThreshold = spT[i];
            eraseThreshold = erT[i];
            for (int w = 0; w < 4 && thresholdExceeded !== want[i]; w++)
                @(negedge clk);
            check_val({47'h0, thresholdExceeded}, {47'h0, want[i]},
                      "verdict");
        end
    endtask

    // Back-to-back error pulses, one uncorrectable beside a bus error
    task automatic s_errors();
        logic [2:0] pat [5] = '{3'b110, 3'b110, 3'b110, 3'b101, 3'b100};
        for (int i = 0; i < 6; i++) begin
            @(negedge clk);
            {eccErrEvt, eccErrCorrectable, crcErrEvt} = (i < 5) ? pat[i]
                                                                : 3'b000;
            check_val({47'h0, thresholdExceeded}, 48'h0, "verdict");
        end
        s_sector(32'd5, 32'd3, 32'd1);
    endtask

    // A recovered chip lifts the value; the worst value stays low
    task automatic s_worst();
        logic [7:0] d;
        bit         ok;
        chipCurSpare[2] = 16'd20;
        repeat (600) @(negedge clk);  // Two full scans
        har_host_model_i.read_byte(9'h005, d, ok);
        check_val({40'h0, d}, 48'h4b, "spare value");
        har_host_model_i.read_byte(9'h006, d, ok);
        check_val({40'h0, d}, 48'h19, "spare worst");
        har_host_model_i.read_byte(9'h013, d, ok);
        check_val({40'h0, d}, 48'h0a, "worst chip");
    endtask

    // Mid-run reset clears the counters and sets the worst value back to 64h
    task automatic s_reset();
        logic [7:0] d;
        bit         ok;
        rst_b = 1'b0;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        har_host_model_i.read_byte(9'h02b, d, ok);
        check_val({40'h0, d}, 48'h0, "count after reset");
        har_host_model_i.read_byte(9'h006, d, ok);
        check_val({40'h0, d}, 48'h64, "worst after reset");
    endtask

    // Guard against a hang anywhere in the run
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        complete_run();
    end

    // Chips at 75, 100, 25 and 100 percent; 300 of 1000 erases used
    initial begin
        num_errors = 0;
        checks = 0;
        rst_b = 1'b0;
        chipInitSpare = {16'd10, 16'd20, 16'd50, 16'd40};
        chipCurSpare = {16'd10, 16'd5, 16'd50, 16'd30};
        eraseTotal = 48'd300;
        eraseBudget = 48'd1000;
        {eccErrEvt, eccErrCorrectable, crcErrEvt} = 3'b000;
        spareThreshold = 8'h00;
        eraseThreshold = 8'h00;
        repeat (6) @(negedge clk);
        rst_b = 1'b1;
        repeat (500) @(negedge clk);  // Background scan needs ~300 cycles
        s_sector(32'd0, 32'd0, 32'd0);
        s_verdict();
        s_errors();
        s_worst();
        s_reset();
        complete_run();
    end
endmodule

`default_nettype wire
